// File: pkg/posl_defs.vh
// Constants for the power-on strap latch: offsets, fields, reset values
`ifndef POSL_DEFS_VH
`define POSL_DEFS_VH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define POSL_OFS_STRAPS 12'h000
`define POSL_OFS_BOOT 12'h004
`define POSL_OFS_CTRL 12'h008
`define POSL_OFS_PULLS 12'h00C
// ****************************************
// Strap register field positions
// ****************************************
`define POSL_BIT_XTAL 0
`define POSL_BIT_WIRELESS 1
`define POSL_BIT_ODT 2
`define POSL_BIT_PORT1 3
`define POSL_BIT_PORT2 4
`define POSL_BIT_DBGRES 5
`define POSL_BIT_DEEPRES 6
`define POSL_BIT_DBGMODE 7
`define POSL_BIT_RESA 8
`define POSL_BIT_RESB 9
`define POSL_BIT_FLASHV 10
`define POSL_BIT_BADSTRAP 11
// ****************************************
// Boot code encodings
// ****************************************
`define POSL_BOOT_HOST_ESPI 4'h0
`define POSL_BOOT_HOST_NOESPI 4'h2
`define POSL_BOOT_ESPI_BIOS 4'h4
`define POSL_BOOT_ESPI_ALL 4'h8
`define POSL_BOOT_ESPI_SLV 4'hC
`define POSL_MODE_RESERVED 3'h0
`define POSL_MODE_HOST_ESPI 3'h1
`define POSL_MODE_HOST_NOESPI 3'h2
`define POSL_MODE_ESPI_BIOS 3'h3
`define POSL_MODE_ESPI_ALL 3'h4
`define POSL_MODE_ESPI_SLV 3'h5
// ****************************************
// Reset values
// ****************************************
`define POSL_RST_STRAPS 10'h080
`define POSL_RST_BOOT 4'h0
`define POSL_RST_CTRL 32'h00000000
// ****************************************
// Reference frequencies in kHz
// ****************************************
`define POSL_XTAL_LOW_KHZ 32'h00009600
`define POSL_XTAL_HIGH_KHZ 32'h00005DC0
`endif

// File: src/posl_sync.v
// Two-flop synchroniser bank for strap and power-good pins
`timescale 1ns/100ps
module posl_sync #(
  parameter WIDTH = 16
) (
  input wire mclk,
  input wire sys_rst,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;
  // First stage feeds only the second stage
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      stage1 <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // posl_sync

// File: src/posl_strap_latch.v
// Power-on strap latch with AHB-Lite status and control registers
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
`include "posl_defs.vh"
// Contract
// [R01] Resume reset rise latches crystal strap: 0 is 38.4 MHz, 1 is 24 MHz.
// [R02] Resume reset rise latches wireless strap: 0 enables, 1 disables wireless.
// [R03] Resume reset rise samples termination strap; 1 enables termination, no pull.
// [R04] Resume reset rise samples port-1 voltage strap: 0 is 1.8 V, 1 is 3.3 V.
// [R05] Resume reset rise samples port-2 voltage strap: 0 is 1.8 V, 1 is 3.3 V.
// [R06] Resume reset rise latches boot code bits 1..3; bit 0 from another strap.
// [R07] Board holds debug reserved strap low at hub power-good rise.
// [R08] Hub power-good high disables pull-downs of straps sampled there.
// [R09] Resume reset deassertion disables pull-downs of straps sampled there.
// [R10] Deep-well strap sampled at deep-sleep power-good rise, pull released after.
// [R11] Debug mode strap pulled up, sampled high; pull-up released after reset.
// [R12] Board lets both reserved low straps sample low at resume reset rise.
// [R13] Flash voltage select never latched: live 0 is 3.3 V, 1 is 1.8 V.
// [R14] Boot code decodes host flash, host flash no eSPI, eSPI variants, else reserved.
// [R15] Latched straps hold until the next assertion of their sampling signal.
module posl_strap_latch (
  input wire mclk,
  input wire sys_rst,
  input wire resume_reset_n,
  input wire hub_power_good,
  input wire deep_sleep_power_good,
  input wire crystal_frequency_strap,
  input wire wireless_mode_strap,
  input wire termination_strap,
  input wire port1_voltage_strap,
  input wire port2_voltage_strap,
  input wire boot_code_bit0,
  input wire boot_code_bit1,
  input wire boot_code_bit2,
  input wire boot_code_bit3,
  input wire debug_reserved_strap,
  input wire deep_well_reserved_strap,
  input wire debug_mode_strap,
  input wire reserved_low_strap_a,
  input wire reserved_low_strap_b,
  input wire flash_io_voltage_select,
  output reg crystalIs24MHz,
  output reg wirelessEnable,
  output reg onDieTermination,
  output reg displayPortOne3v3,
  output reg displayPortTwo3v3,
  output reg [3:0] bootCode,
  output reg [2:0] bootMode,
  output reg debugReserved,
  output reg deepWellReserved,
  output reg debugMode,
  output reg flashIo1v8,
  output reg resumePullDownEn,
  output reg debugModePullUpEn,
  output reg hubPullDownEn,
  output reg deepPullDownEn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  // Every pin, sampling signals included, crosses through two flops
  wire [17:0] pinRaw;
  wire [17:0] pinSync;
  assign pinRaw = {flash_io_voltage_select, reserved_low_strap_b, reserved_low_strap_a,
                   debug_mode_strap, deep_well_reserved_strap, debug_reserved_strap,
                   boot_code_bit3, boot_code_bit2, boot_code_bit1, boot_code_bit0,
                   port2_voltage_strap, port1_voltage_strap, termination_strap,
                   wireless_mode_strap, crystal_frequency_strap,
                   deep_sleep_power_good, hub_power_good, resume_reset_n};

  // One bank keeps straps and sampling signals aligned in time
  posl_sync #(.WIDTH(18)) uSync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .asyncIn(pinRaw),
    .syncOut(pinSync)
  );

  // Named views of the synchronised pins
  wire resumeS = pinSync[0];
  wire hubS = pinSync[1];
  wire deepS = pinSync[2];
  wire xtalS = pinSync[3];
  wire wirelessS = pinSync[4];
  wire odtS = pinSync[5];
  wire port1S = pinSync[6];
  wire port2S = pinSync[7];
  wire [3:0] bootS = pinSync[11:8];
  wire dbgResS = pinSync[12];
  wire deepResS = pinSync[13];
  wire dbgModeS = pinSync[14];
  wire resAS = pinSync[15];
  wire resBS = pinSync[16];
  wire flashS = pinSync[17];

  // ****************************************
  // Edge detection on sampling signals
  // ****************************************
  // Last synchronised level of each sampling signal
  reg resumePrev;
  reg hubPrev;
  reg deepPrev;
  // One-cycle strobe at each synchronised rise
  wire resumeRise = resumeS & ~resumePrev;
  wire hubRise = hubS & ~hubPrev;
  wire deepRise = deepS & ~deepPrev;

  // Previous levels reset low so a signal high out of reset counts as a rise
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      resumePrev <= 1'b0;
      hubPrev <= 1'b0;
      deepPrev <= 1'b0;
    end
    else
    begin
      resumePrev <= resumeS;
      hubPrev <= hubS;
      deepPrev <= deepS;
    end
  end

  // ****************************************
  // Registers reachable over the bus
  // ****************************************
  // Bus-visible state with no port of its own
  reg [31:0] ctrl;
  reg resALatched;
  reg resBLatched;
  reg badStrap;

  // ****************************************
  // Resume reset domain straps
  // ****************************************
  // Values change only at a rise, so later pin activity is ignored
  // Debug mode resets high to match its internal pull-up
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      crystalIs24MHz <= 1'b0;
      wirelessEnable <= 1'b0;
      onDieTermination <= 1'b0;
      displayPortOne3v3 <= 1'b0;
      displayPortTwo3v3 <= 1'b0;
      bootCode <= `POSL_RST_BOOT;
      debugMode <= 1'b1;
      resALatched <= 1'b0;
      resBLatched <= 1'b0;
    end
    else if (resumeRise) // see [R15]
    begin
      crystalIs24MHz <= xtalS; // see [R01]
      wirelessEnable <= ~wirelessS; // see [R02]
      onDieTermination <= odtS; // see [R03]
      displayPortOne3v3 <= port1S; // see [R04]
      displayPortTwo3v3 <= port2S; // see [R05]
      bootCode <= bootS; // see [R06]
      debugMode <= dbgModeS; // see [R11]
      resALatched <= resAS; // see [R12]
      resBLatched <= resBS; // see [R12]
    end
  end

  // ****************************************
  // Power-good domain straps
  // ****************************************
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      debugReserved <= 1'b0;
      deepWellReserved <= 1'b0;
    end
    else
    begin
      if (hubRise) // see [R15]
        debugReserved <= dbgResS; // see [R07]
      if (deepRise) // see [R15]
        deepWellReserved <= deepResS; // see [R10]
    end
  end

  // Flags a board that drove a strap against its required level
  // A resume rise recomputes its own part, but a hub or deep violation in
  // the same cycle still sets the flag; a hub or deep violation from an earlier cycle is cleared
  wire resumeBad = ~dbgModeS | resAS | resBS; // see [R11] [R12]
  wire hubBad = hubRise & dbgResS; // see [R07]
  wire deepBad = deepRise & deepResS; // see [R10]
  always @(posedge mclk)
  begin
    if (sys_rst)
      badStrap <= 1'b0;
    else if (resumeRise)
      badStrap <= resumeBad | hubBad | deepBad;
    else if (hubBad | deepBad)
      badStrap <= 1'b1;
  end

  // ****************************************
  // Pull resistor control
  // ****************************************
  // Pulls stay on while the sampling signal is low, off once it is high
  // A pull returns as soon as its sampling signal drops again
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      resumePullDownEn <= 1'b1;
      debugModePullUpEn <= 1'b1;
      hubPullDownEn <= 1'b1;
      deepPullDownEn <= 1'b1;
    end
    else
    begin
      resumePullDownEn <= ~(resumeS & resumePrev); // see [R09]
      debugModePullUpEn <= ~(resumeS & resumePrev); // see [R11]
      hubPullDownEn <= ~(hubS & hubPrev); // see [R08]
      deepPullDownEn <= ~(deepS & deepPrev); // see [R10]
    end
  end

  // ****************************************
  // Live flash voltage and boot decode
  // ****************************************
  // Reserved codes decode to mode 0
  reg [2:0] next_bootMode;
  always @*
  begin
    case (bootCode)
      `POSL_BOOT_HOST_ESPI: next_bootMode = `POSL_MODE_HOST_ESPI; // see [R14]
      `POSL_BOOT_HOST_NOESPI: next_bootMode = `POSL_MODE_HOST_NOESPI;
      `POSL_BOOT_ESPI_BIOS: next_bootMode = `POSL_MODE_ESPI_BIOS;
      `POSL_BOOT_ESPI_ALL: next_bootMode = `POSL_MODE_ESPI_ALL;
      `POSL_BOOT_ESPI_SLV: next_bootMode = `POSL_MODE_ESPI_SLV;
      default: next_bootMode = `POSL_MODE_RESERVED;
    endcase
  end

  // Flash select follows the pin continuously, never held
  // Lag is three flops: two to synchronise, one here
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bootMode <= `POSL_MODE_RESERVED;
      flashIo1v8 <= 1'b0;
    end
    else
    begin
      bootMode <= next_bootMode;
      flashIo1v8 <= flashS; // see [R13]
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Zero wait states; every access answers OKAY
  // Address phase captured for the data phase that follows
  reg dataPhase;
  reg dataWrite;
  reg [11:0] dataAddr;
  wire addrTake = hsel & htrans[1] & hready;

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr <= 12'h000;
    end
    else
    begin
      dataPhase <= addrTake;
      dataWrite <= addrTake & hwrite;
      if (addrTake)
        dataAddr <= haddr;
    end
  end

  // No wait states, so the slave never stretches a transfer
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Scratch control word; software can park platform hints here
  always @(posedge mclk)
  begin
    if (sys_rst)
      ctrl <= `POSL_RST_CTRL;
    else if (dataPhase & dataWrite & (dataAddr == `POSL_OFS_CTRL))
      ctrl <= hwdata;
  end

  // Read mux, registered at the address phase so data stand in the data phase
  reg [31:0] next_hrdata;
  always @*
  begin
    next_hrdata = 32'h00000000;
    case (haddr)
      `POSL_OFS_STRAPS:
      begin
        next_hrdata[`POSL_BIT_XTAL] = crystalIs24MHz;
        next_hrdata[`POSL_BIT_WIRELESS] = wirelessEnable;
        next_hrdata[`POSL_BIT_ODT] = onDieTermination;
        next_hrdata[`POSL_BIT_PORT1] = displayPortOne3v3;
        next_hrdata[`POSL_BIT_PORT2] = displayPortTwo3v3;
        next_hrdata[`POSL_BIT_DBGRES] = debugReserved;
        next_hrdata[`POSL_BIT_DEEPRES] = deepWellReserved;
        next_hrdata[`POSL_BIT_DBGMODE] = debugMode;
        next_hrdata[`POSL_BIT_RESA] = resALatched;
        next_hrdata[`POSL_BIT_RESB] = resBLatched;
        next_hrdata[`POSL_BIT_FLASHV] = flashIo1v8;
        next_hrdata[`POSL_BIT_BADSTRAP] = badStrap;
      end
      `POSL_OFS_BOOT: next_hrdata = {25'h0000000, bootMode, bootCode};
      `POSL_OFS_CTRL: next_hrdata = ctrl;
      `POSL_OFS_PULLS: next_hrdata = {28'h0000000, deepPullDownEn, hubPullDownEn,
                                      debugModePullUpEn, resumePullDownEn};
      default: next_hrdata = 32'h00000000;
    endcase
  end

  // Only a read refreshes the data; writes leave it untouched
  always @(posedge mclk)
  begin
    if (sys_rst)
      hrdata <= 32'h00000000;
    else if (addrTake & ~hwrite)
      hrdata <= next_hrdata;
  end
endmodule // posl_strap_latch

// File: tb/posl_board_model.sv
// Board side of the strap pins: external drivers, internal pulls, floating pins
`timescale 1ns/100ps
module posl_board_model (
  input wire mclk,
  input wire [14:0] drv,
  input wire [14:0] drvEn,
  input wire [3:0] pull,
  output logic [14:0] pin
);
  // *****
  // Pin levels
  // *****
  logic [14:0] flt = 15'h0000;
  logic [14:0] pullOn;
  // Pull map {deep,hub,dbgUp,resume}; no pull on wireless, termination, flash
  assign pullOn = {{4{pull[0]}}, 1'b0, {2{pull[0]}}, pull[1], pull[3], pull[2],
    {2{pull[0]}}, 2'b00, pull[0]};
  // A pin nobody holds flips every cycle, so a stale level never passes
  always @(posedge mclk)
    flt <= ~flt;
  // Driver wins, then the pull level (only the debug mode pull is up)
  assign pin = (drvEn & drv) | (~drvEn & pullOn & 15'h0080) | (~drvEn & ~pullOn & flt);
endmodule // posl_board_model

// File: tb/posl_strap_latch_properties.sv
// Port checker for the power-on strap latch
`timescale 1ns/100ps
module posl_strap_latch_properties (
  input wire mclk,
  input wire sys_rst,
  input wire resume_reset_n,
  input wire hub_power_good,
  input wire deep_sleep_power_good,
  input wire crystal_frequency_strap,
  input wire wireless_mode_strap,
  input wire flash_io_voltage_select,
  input wire crystalIs24MHz,
  input wire wirelessEnable,
  input wire displayPortOne3v3,
  input wire [3:0] bootCode,
  input wire [2:0] bootMode,
  input wire flashIo1v8,
  input wire resumePullDownEn,
  input wire debugModePullUpEn,
  input wire hubPullDownEn,
  input wire deepPullDownEn
);
  // *****
  // Helpers
  // *****
  logic [2:0] age;
  // Edges since reset release; the sync flops need time to fill
  always @(posedge mclk)
    if (sys_rst) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  function automatic logic [2:0] modeOf(input logic [3:0] c);
    return (c == 4'h0) ? 3'h1 : (c == 4'h2) ? 3'h2 : (c == 4'h4) ? 3'h3 :
      (c == 4'h8) ? 3'h4 : (c == 4'hC) ? 3'h5 : 3'h0;
  endfunction
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // *****
  // Properties
  // *****
  a_resume_pull_off: assert property (
    $rose(resume_reset_n) |-> ##[1:6] !resumePullDownEn) else $error("pull-down stays on");
  a_debug_pullup_off: assert property (
    $rose(resume_reset_n) |-> ##[1:6] !debugModePullUpEn) else $error("pull-up stays on");
  a_hub_pull_off: assert property (
    $rose(hub_power_good) |-> ##[1:6] !hubPullDownEn) else $error("hub pull stays on");
  a_deep_pull_off: assert property (
    $rose(deep_sleep_power_good) |-> ##[1:6] !deepPullDownEn) else $error("deep pull on");
  a_xtal_latched: assert property (
    $rose(resume_reset_n) ##0 $stable(crystal_frequency_strap) [*6]
    |-> crystalIs24MHz == crystal_frequency_strap) else $error("crystal strap wrong");
  a_wireless_latched: assert property (
    $rose(resume_reset_n) ##0 $stable(wireless_mode_strap) [*6]
    |-> wirelessEnable != wireless_mode_strap) else $error("wireless strap wrong");
  a_latch_holds: assert property (
    resume_reset_n [*8] |=> $stable(displayPortOne3v3) && $stable(bootCode))
    else $error("latched strap moved");
  a_boot_decode: assert property (
    age == 3'h7 && $stable(bootCode) |-> bootMode == modeOf(bootCode))
    else $error("boot mode wrong");
  a_flash_live: assert property (
    age == 3'h7 |-> flashIo1v8 == $past(flash_io_voltage_select, 3))
    else $error("flash select not live");
  c_resume_rise: cover property ($rose(resume_reset_n));
  c_hub_rise: cover property ($rose(hub_power_good));
  c_boot_top: cover property (bootMode == 3'h5);
endmodule // posl_strap_latch_properties
bind posl_strap_latch posl_strap_latch_properties i_posl_strap_latch_properties (.*);

// File: tb/posl_strap_latch_test.sv
// Self-checking testbench for the power-on strap latch
`timescale 1ns/100ps
`include "posl_defs.vh"
module posl_strap_latch_test;
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic rstN = 1'b0;
  logic hubPg = 1'b0;
  logic deepPg = 1'b0;
  logic [14:0] drv = 15'h0080;
  logic [14:0] drvEn = 15'h7FFF;
  logic [14:0] pin;
  logic [14:0] lat;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rdPh = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] v;
  logic [31:0] expWord;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  logic [11:0] adrQ[$];
  wire [31:0] hrdata;
  wire hreadyout;
  wire [3:0] pull;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int i;
  always #12.5 mclk = ~mclk;
  posl_strap_latch i_posl_strap_latch (.mclk(mclk), .sys_rst(sysRst),
    .resume_reset_n(rstN), .hub_power_good(hubPg), .deep_sleep_power_good(deepPg),
    .crystal_frequency_strap(pin[0]), .wireless_mode_strap(pin[1]),
    .termination_strap(pin[2]), .port1_voltage_strap(pin[3]), .port2_voltage_strap(pin[4]),
    .debug_reserved_strap(pin[5]), .deep_well_reserved_strap(pin[6]),
    .debug_mode_strap(pin[7]), .reserved_low_strap_a(pin[8]), .reserved_low_strap_b(pin[9]),
    .flash_io_voltage_select(pin[10]), .boot_code_bit0(pin[11]), .boot_code_bit1(pin[12]),
    .boot_code_bit2(pin[13]), .boot_code_bit3(pin[14]), .crystalIs24MHz(),
    .wirelessEnable(), .onDieTermination(), .displayPortOne3v3(), .displayPortTwo3v3(),
    .bootCode(), .bootMode(), .debugReserved(), .deepWellReserved(), .debugMode(),
    .flashIo1v8(), .resumePullDownEn(pull[0]), .debugModePullUpEn(pull[1]),
    .hubPullDownEn(pull[2]), .deepPullDownEn(pull[3]), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp());
  posl_board_model i_posl_board_model (.mclk(mclk), .drv(drv), .drvEn(drvEn),
    .pull(pull), .pin(pin));
  // *****
  // Bus and checking
  // *****
  function automatic logic [2:0] modeOf(input logic [3:0] c);
    return (c == 4'h0) ? 3'h1 : (c == 4'h2) ? 3'h2 : (c == 4'h4) ? 3'h3 :
      (c == 4'h8) ? 3'h4 : (c == 4'hC) ? 3'h5 : 3'h0;
  endfunction
  // Single word transfer; address held until ready, then data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdPh <= !w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rdPh <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
    input logic [31:0] m = 32'hFFFFFFFF);
    adrQ.push_back(a);
    expQ.push_back(e);
    mskQ.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic cmp(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    checked++;
    if ((hrdata & m) !== e)
    begin
      error_cnt++;
      $display("[FAIL] read %h expected %h seen %h", a, e, hrdata & m);
    end
  endtask
  // Oldest note is taken at the edge that ends each read data phase
  always @(posedge mclk)
    if (rdPh && hreadyout === 1'b1) cmp(adrQ.pop_front(), expQ.pop_front(), mskQ.pop_front());
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, far above the roughly 430 cycles the run needs
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  // *****
  // Scenarios
  // *****
  initial
  begin
    void'($urandom(32'h3B58C2B5));
    repeat (10) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    rd(`POSL_OFS_PULLS, 32'hF);
    rd(`POSL_OFS_BOOT, {25'h0, modeOf(`POSL_RST_BOOT), `POSL_RST_BOOT});
    v = $urandom;
    bus(1'b1, `POSL_OFS_CTRL, v);
    bus(1'b1, `POSL_OFS_STRAPS, 32'hFFFFFFFF);
    rd(`POSL_OFS_CTRL, v);
    rd(`POSL_OFS_STRAPS, 32'h80);
    rd(12'h010, 32'h0);
    // Every boot code; first pass leaves pulled pins to the internal pulls
    for (i = 0; i < 16; i++)
    begin
      v = $urandom;
      drvEn <= (i == 0) ? 15'h0406 : 15'h7FFF;
      drv <= {i[3:0], v[10], 1'b0, i == 15, 3'h4, v[4:0]};
      rstN <= 1'b0;
      repeat (6) @(posedge mclk);
      lat = drv & ((i == 0) ? 15'h0486 : 15'h7FFF);
      rstN <= 1'b1;
      repeat (8) @(posedge mclk);
      rd(`POSL_OFS_PULLS, 32'hC);
      v = $urandom;
      drv <= v[14:0];
      drvEn <= 15'h7FFF;
      repeat (4) @(posedge mclk);
      expWord = {20'h0, i == 15, v[10], lat[9:0] ^ 10'h002};
      rd(`POSL_OFS_STRAPS, expWord);
      rd(`POSL_OFS_BOOT, {25'h0, modeOf(lat[14:11]), lat[14:11]});
    end
    drv <= 15'h00A0;
    hubPg <= 1'b1;
    deepPg <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(`POSL_OFS_PULLS, 32'h0);
    rd(`POSL_OFS_STRAPS, {22'h0, lat[9:0] ^ 10'h002} | 32'h820);
    hubPg <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(`POSL_OFS_PULLS, 32'h4);
    report_and_stop();
  end
endmodule // posl_strap_latch_test
